// [rtl/periph_irq_flags.sv]
// Purpose: Peripheral flag groups two and three, enable group one and
//          the combined peripheral interrupt request.
// Assumes: Event inputs are one-cycle pulses synchronous to CLK_SYS.
// Notes:   Register reads return data in the cycle after the strobe.
`timescale 1ns/100ps

// Behaviour
// - Oscillator failure sets sticky flag bit 7.
// - Comparator input change sets sticky bit 6.
// - NVM write done sets bit 4; busy reads zero.
// - Serial port bus collision sets bit 3.
// - Voltage trip sets sticky bit 2.
// - Timer-3 overflow sets sticky bit 1.
// - Capture or compare sets bit 0; not PWM.
// - Small variant: comparator and capcomp bits reserved.
// - Invalid CAN message sets bit 7.
// - CAN bus activity sets wake bit 6.
// - Any CAN error source sets bit 5.
// - Bit 4: buffer two, or any transmit buffer.
// - Buffer one/zero flags; forced zero in modes 1,2,3.
// - Bit 1: receive buffer one, or any.
// - Bit 0: buffer zero, zero, or watermark.
// - Enable group one enables eight peripheral sources.
// - Without priority mode, enables need peripheral gate.
// - Flags set regardless of any enable bit.
// - Peripheral gate is low-priority enable in priority mode.
module periph_irq_flags
   import irq_flags_pkg::*;
#(
   parameter bit LARGE_VARIANT = 1'b1
) (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [DATA_W-1:0] WDATA,
   input wire logic WR_EN,
   input wire logic RD_EN,
   output logic [DATA_W-1:0] RDATA,
   input wire flags_two_s EV_TWO,
   input wire logic NVM_WRITE_BUSY,
   input wire logic ECCP_PWM_MODE,
   input wire can_events_s EV_CAN,
   input wire logic [1:0] CAN_MODE,
   input wire logic [7:0] FLAGS_ONE,
   input wire logic [7:0] ENABLES_TWO,
   input wire logic [7:0] ENABLES_THREE,
   output logic PRIORITY_MODE,
   output logic PERIPH_IRQ
);
   logic rst_n;
   can_mode_e mode;
   logic [15:0] set_all;
   logic [15:0] hold_all;
   logic [15:0] wr_all;
   logic [15:0] q_all;
   flags_two_s two_q;
   can_flags_s can_q;
   flags_two_s two_set;
   can_flags_s can_set;
   flags_two_s two_hold;
   can_flags_s can_hold;
   logic wr_two;
   logic wr_can;
   logic [7:0] enables_one_d;
   logic [7:0] enables_one_q;
   logic prio_d;
   logic prio_q;
   logic gate_d;
   logic gate_q;
   logic [7:0] rdata_d;
   logic [7:0] rdata_q;
   logic pending;
   logic irq_d;
   logic irq_q;

   reset_sync u_rst (
      .clk(CLK_SYS),
      .rst_in_n(RST_N),
      .rst_out_n(rst_n)
   );

   assign mode = can_mode_e'(CAN_MODE);
   assign wr_two = WR_EN && (ADDR == OFS_FLAGS_TWO);
   assign wr_can = WR_EN && (ADDR == OFS_CAN_FLAGS);

   // Set sources of the second group; enables are never consulted
   always_comb begin
      two_set = '0;
      two_hold = '0;
      two_set.osc_fail_flag = EV_TWO.osc_fail_flag;
      two_set.comparator_change_flag = EV_TWO.comparator_change_flag;
      two_set.nvm_write_done_flag = EV_TWO.nvm_write_done_flag;
      two_set.bus_collision_flag = EV_TWO.bus_collision_flag;
      two_set.voltage_detect_flag = EV_TWO.voltage_detect_flag;
      two_set.timer3_overflow_flag = EV_TWO.timer3_overflow_flag;
      // PWM mode makes no capture or compare events
      two_set.enh_capcomp_flag = EV_TWO.enh_capcomp_flag && !ECCP_PWM_MODE;
      two_hold.unused_flag = 1'b1;
      // A write in progress must read as not complete
      two_hold.nvm_write_done_flag = NVM_WRITE_BUSY;
      // Reserved bits on the small variant never hold a one
      two_hold.comparator_change_flag = !LARGE_VARIANT;
      two_hold.enh_capcomp_flag = !LARGE_VARIANT;
   end

   // CAN group sources follow the operating mode; the spare mode code
   // is treated like FIFO mode so no bit is left without a meaning
   always_comb begin
      can_set = '0;
      can_hold = '0;
      can_set.can_invalid_msg_flag = EV_CAN.invalid_msg;
      can_set.can_wake_flag = EV_CAN.wake;
      can_set.can_error_flag = EV_CAN.error;
      unique case (mode)
         CAN_MODE_LEGACY: begin
            can_set.any_tx_buffer_flag = EV_CAN.tx_two_done;
            can_set.tx_buffer_one_flag = EV_CAN.tx_one_done;
            can_set.tx_buffer_zero_flag = EV_CAN.tx_zero_done;
            can_set.any_rx_buffer_flag = EV_CAN.rx_one_new;
            can_set.rx_buffer_zero_flag = EV_CAN.rx_zero_new;
         end
         CAN_MODE_ENHANCED: begin
            can_set.any_tx_buffer_flag = EV_CAN.any_tx_done;
            can_hold.tx_buffer_one_flag = 1'b1;
            can_hold.tx_buffer_zero_flag = 1'b1;
            can_set.any_rx_buffer_flag = EV_CAN.any_rx_new;
            can_hold.rx_buffer_zero_flag = 1'b1;
         end
         CAN_MODE_FIFO, CAN_MODE_SPARE: begin
            can_set.any_tx_buffer_flag = EV_CAN.any_tx_done;
            can_hold.tx_buffer_one_flag = 1'b1;
            can_hold.tx_buffer_zero_flag = 1'b1;
            can_set.any_rx_buffer_flag = EV_CAN.any_rx_new;
            can_set.rx_buffer_zero_flag = EV_CAN.fifo_watermark;
         end
      endcase
   end

   assign set_all = {can_set, two_set};
   assign hold_all = {can_hold, two_hold};
   assign wr_all = {{8{wr_can}}, {8{wr_two}}};

   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++) begin : g_flag
         flag_cell u_cell (
            .clk(CLK_SYS),
            .rst_n(rst_n),
            .set_i(set_all[gi]),
            .wr_i(wr_all[gi]),
            .wdata_i(WDATA[gi % 8]),
            .hold_zero_i(hold_all[gi]),
            .q_o(q_all[gi])
         );
      end
   endgenerate

   assign two_q = flags_two_s'(q_all[7:0]);
   assign can_q = can_flags_s'(q_all[15:8]);

   // Enable and control registers
   always_comb begin
      enables_one_d = enables_one_q;
      prio_d = prio_q;
      gate_d = gate_q;
      if (WR_EN && (ADDR == OFS_ENABLES_ONE)) begin
         enables_one_d = WDATA;
      end
      if (WR_EN && (ADDR == OFS_IRQ_CTRL)) begin
         prio_d = WDATA[CTRL_PRIO_BIT];
         gate_d = WDATA[CTRL_GATE_BIT];
      end
   end

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         enables_one_q <= RST_ENABLES;
         prio_q <= 1'b0;
         gate_q <= 1'b0;
      end else begin
         enables_one_q <= enables_one_d;
         prio_q <= prio_d;
         gate_q <= gate_d;
      end
   end

   // Read data live for one cycle only; unmapped offsets read zero
   always_comb begin
      rdata_d = RST_RDATA;
      if (RD_EN) begin
         unique case (ADDR)
            OFS_FLAGS_TWO: rdata_d = q_all[7:0];
            OFS_CAN_FLAGS: rdata_d = q_all[15:8];
            OFS_ENABLES_ONE: rdata_d = enables_one_q;
            OFS_IRQ_CTRL: begin
               rdata_d[CTRL_PRIO_BIT] = prio_q;
               rdata_d[CTRL_GATE_BIT] = gate_q;
            end
            default: rdata_d = RST_RDATA;
         endcase
      end
   end

   // Request: every flag that its enable lets through
   assign pending = |(FLAGS_ONE & enables_one_q)
                  | |(q_all[7:0] & ENABLES_TWO)
                  | |(q_all[15:8] & ENABLES_THREE);

   // With priority off the gate unmasks all enabled sources
   // with priority on it stands as the low-priority enable, so the
   // same term feeds the low-priority arbiter outside
   always_comb begin
      irq_d = pending && gate_q;
   end

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= RST_RDATA;
         irq_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         irq_q <= irq_d;
      end
   end

   assign RDATA = rdata_q;
   assign PERIPH_IRQ = irq_q;
   assign PRIORITY_MODE = prio_q;

   // Checks
   a_osc_fail_set: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
      EV_TWO.osc_fail_flag |=> two_q.osc_fail_flag)
      else $error("oscillator fail flag not set");

   a_osc_flag_hold: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
      (two_q.osc_fail_flag && !wr_two) |=> two_q.osc_fail_flag)
      else $error("oscillator fail flag dropped without write");

   a_cmp_change_set: assert property (@(posedge CLK_SYS)
      disable iff (!rst_n)
      (EV_TWO.comparator_change_flag && LARGE_VARIANT)
      |=> two_q.comparator_change_flag)
      else $error("comparator flag not set");

   a_nvm_busy_zero: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
      NVM_WRITE_BUSY |=> !two_q.nvm_write_done_flag)
      else $error("write done flag set while busy");

   a_nvm_done_set: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
      (EV_TWO.nvm_write_done_flag && !NVM_WRITE_BUSY)
      |=> two_q.nvm_write_done_flag)
      else $error("write done flag not set");

   a_collision_set: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
      EV_TWO.bus_collision_flag |=> two_q.bus_collision_flag)
      else $error("bus collision flag not set");

   a_voltage_set: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
      EV_TWO.voltage_detect_flag |=> two_q.voltage_detect_flag)
      else $error("voltage detect flag not set");

   a_timer3_set: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
      (EV_TWO.timer3_overflow_flag && wr_two && !WDATA[1])
      |=> two_q.timer3_overflow_flag)
      else $error("timer3 event lost against clear");

   a_pwm_no_set: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
      (ECCP_PWM_MODE && !two_q.enh_capcomp_flag && !wr_two)
      |=> !two_q.enh_capcomp_flag)
      else $error("capcomp flag set in PWM mode");

   a_small_reserved: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
      !LARGE_VARIANT |=> (!two_q.comparator_change_flag
                          && !two_q.enh_capcomp_flag))
      else $error("reserved flag set on small variant");

   a_can_error_set: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
      EV_CAN.error |=> can_q.can_error_flag)
      else $error("CAN error flag not set");

   a_mode_tx_any: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
      (mode != CAN_MODE_LEGACY && EV_CAN.any_tx_done)
      |=> can_q.any_tx_buffer_flag)
      else $error("any transmit flag not set");

   a_tx_forced_zero: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
      (mode != CAN_MODE_LEGACY) |=> (!can_q.tx_buffer_one_flag
                                     && !can_q.tx_buffer_zero_flag))
      else $error("buffer flags not forced to zero");

   a_rx_legacy_set: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
      (mode == CAN_MODE_LEGACY && EV_CAN.rx_one_new)
      |=> can_q.any_rx_buffer_flag)
      else $error("receive buffer one flag not set");

   a_bit0_by_mode: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
      (mode == CAN_MODE_ENHANCED) |=> !can_q.rx_buffer_zero_flag)
      else $error("bit 0 not zero in mode 1");

   a_fifo_wm_set: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
      (mode == CAN_MODE_FIFO && EV_CAN.fifo_watermark)
      |=> can_q.rx_buffer_zero_flag)
      else $error("watermark flag not set in mode 2");

   a_can_wake_set: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
      EV_CAN.wake |=> can_q.can_wake_flag)
      else $error("CAN wake flag not set");

   a_invalid_set: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
      EV_CAN.invalid_msg |=> can_q.can_invalid_msg_flag)
      else $error("invalid message flag not set");

   a_gate_blocks: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
      (!gate_q && !prio_q) |=> !PERIPH_IRQ)
      else $error("request without peripheral gate");

   a_enable_one_req: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
      (gate_q && |(FLAGS_ONE & enables_one_q)) |=> PERIPH_IRQ)
      else $error("enabled group one source not requested");

   a_request_form: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
      (gate_q && pending) |=> PERIPH_IRQ)
      else $error("pending enabled flag not requested");

   a_read_one_cycle: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
      !RD_EN |=> (RDATA == RST_RDATA))
      else $error("read data outside the answer cycle");

   c_irq_raised: cover property (@(posedge CLK_SYS) disable iff (!rst_n)
      !PERIPH_IRQ ##1 PERIPH_IRQ);

   c_fifo_watermark: cover property (@(posedge CLK_SYS) disable iff (!rst_n)
      mode == CAN_MODE_FIFO && EV_CAN.fifo_watermark
      ##1 can_q.rx_buffer_zero_flag);

   c_set_on_clear: cover property (@(posedge CLK_SYS) disable iff (!rst_n)
      EV_TWO.osc_fail_flag && wr_two && !WDATA[7]);

   c_busy_blocks_done: cover property (@(posedge CLK_SYS)
      disable iff (!rst_n)
      NVM_WRITE_BUSY && EV_TWO.nvm_write_done_flag);

endmodule : periph_irq_flags

// [rtl/irq_flags_pkg.sv]
// Purpose: Shared constants and carriers for the peripheral flag block.
// Assumes: Byte-wide registers on a plain strobe port, one clock.
// Notes:   Offsets are word indices on the register port.
package irq_flags_pkg;

   // Register port geometry
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;

   // Register offsets
   localparam logic [2:0] OFS_FLAGS_TWO = 3'h0;
   localparam logic [2:0] OFS_CAN_FLAGS = 3'h1;
   localparam logic [2:0] OFS_ENABLES_ONE = 3'h2;
   localparam logic [2:0] OFS_IRQ_CTRL = 3'h3;

   // Values after reset
   localparam logic [7:0] RST_FLAGS = 8'h00;
   localparam logic [7:0] RST_ENABLES = 8'h00;
   localparam logic [7:0] RST_RDATA = 8'h00;

   // Field positions inside the control register
   localparam int CTRL_PRIO_BIT = 0;
   localparam int CTRL_GATE_BIT = 1;

   // Unimplemented bit of the second flag group
   localparam int TWO_UNUSED_BIT = 5;

   // CAN operating modes as driven by the CAN controller
   typedef enum logic [1:0] {
      CAN_MODE_LEGACY = 2'h0,
      CAN_MODE_ENHANCED = 2'h1,
      CAN_MODE_FIFO = 2'h2,
      CAN_MODE_SPARE = 2'h3
   } can_mode_e;

   // Second flag group, bit 7 down to bit 0
   typedef struct packed {
      logic osc_fail_flag;
      logic comparator_change_flag;
      logic unused_flag;
      logic nvm_write_done_flag;
      logic bus_collision_flag;
      logic voltage_detect_flag;
      logic timer3_overflow_flag;
      logic enh_capcomp_flag;
   } flags_two_s;

   // CAN event flag group, bit 7 down to bit 0
   typedef struct packed {
      logic can_invalid_msg_flag;
      logic can_wake_flag;
      logic can_error_flag;
      logic any_tx_buffer_flag;
      logic tx_buffer_one_flag;
      logic tx_buffer_zero_flag;
      logic any_rx_buffer_flag;
      logic rx_buffer_zero_flag;
   } can_flags_s;

   // One-cycle event pulses from the CAN controller
   typedef struct packed {
      logic invalid_msg;
      logic wake;
      logic error;
      logic tx_two_done;
      logic tx_one_done;
      logic tx_zero_done;
      logic any_tx_done;
      logic rx_one_new;
      logic rx_zero_new;
      logic any_rx_new;
      logic fifo_watermark;
   } can_events_s;

endpackage : irq_flags_pkg

// [rtl/flag_cell.sv]
// Purpose: One sticky interrupt flag bit with software write access.
// Assumes: Set and write are one-cycle pulses on CLK.
// Notes:   Hold-zero beats set, and set beats a software write.
`timescale 1ns/100ps
module flag_cell (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic set_i,
   input wire logic wr_i,
   input wire logic wdata_i,
   input wire logic hold_zero_i,
   output logic q_o
);
   logic q_d;
   logic q_q;

   always_comb begin
      q_d = q_q;
      if (wr_i) begin
         q_d = wdata_i;
      end
      // An event in the clearing cycle must not be lost
      if (set_i) begin
         q_d = 1'b1;
      end
      if (hold_zero_i) begin
         q_d = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q_q <= 1'b0;
      end else begin
         q_q <= q_d;
      end
   end

   assign q_o = q_q;
endmodule : flag_cell

// [rtl/reset_sync.sv]
// Purpose: Asserts reset at once, releases it after two clock edges.
// Assumes: Reset input is active low and asynchronous.
// Notes:   Only the second stage leaves this module.
`timescale 1ns/100ps
module reset_sync (
   input wire logic clk,
   input wire logic rst_in_n,
   output logic rst_out_n
);
   logic meta_q;
   logic sync_q;

   always_ff @(posedge clk or negedge rst_in_n) begin
      if (!rst_in_n) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= 1'b1;
         sync_q <= meta_q;
      end
   end

   assign rst_out_n = sync_q;
endmodule : reset_sync

// [sim/event_source_model.sv]
// Purpose: Peripheral and CAN event sources that face the flag block.
// Assumes: Each event is a one-cycle pulse launched after a rising edge.
// Notes:   Pulses drop back to zero; no event ever lingers on the lines.
`timescale 1ns/100ps
module event_source_model
   import irq_flags_pkg::*;
(
   input wire logic clk,
   output flags_two_s ev_two,
   output can_events_s ev_can
);
   initial begin
      ev_two = '0;
      ev_can = '0;
   end

   // One pulse per call; the caller picks which sources fire together
   task automatic fire(input flags_two_s t, input can_events_s c);
      @(posedge clk);
      ev_two <= t;
      ev_can <= c;
      @(posedge clk);
      ev_two <= '0;
      ev_can <= '0;
   endtask : fire
endmodule : event_source_model

// [sim/periph_irq_flags_tb_top.sv]
// Purpose: Self-checking bench for the peripheral flag block.
// Assumes: Register port without wait states, read data one cycle later.
// Notes:   A second instance checks the small variant on the same inputs.
`timescale 1ns/100ps
module periph_irq_flags_tb_top
   import irq_flags_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic nvm_busy = 1'b0;
   logic pwm_mode = 1'b0;
   logic [1:0] can_mode = 2'h0;
   logic [7:0] flags_one = 8'h00;
   logic [7:0] en_two = 8'h00;
   logic [7:0] en_three = 8'h00;
   logic [DATA_W-1:0] rdata_l, rdata_s, rl, rs;
   logic prio_l, irq_l, irq_s;
   flags_two_s ev_two;
   can_events_s ev_can;
   int miscompares = 0;
   int n_compared = 0;
   logic [7:0] exp_all [4] = '{8'hFF, 8'hF2, 8'hF3, 8'hF3};
   logic [7:0] exp_leg [4] = '{8'h1F, 8'h00, 8'h00, 8'h00};

   always #10 clk_sys = ~clk_sys;

   event_source_model ev (.clk(clk_sys), .ev_two(ev_two), .ev_can(ev_can));

   periph_irq_flags #(.LARGE_VARIANT(1'b1)) dut (
      .CLK_SYS(clk_sys), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
      .WR_EN(wr_en), .RD_EN(rd_en), .RDATA(rdata_l), .EV_TWO(ev_two),
      .NVM_WRITE_BUSY(nvm_busy), .ECCP_PWM_MODE(pwm_mode),
      .EV_CAN(ev_can), .CAN_MODE(can_mode), .FLAGS_ONE(flags_one),
      .ENABLES_TWO(en_two), .ENABLES_THREE(en_three),
      .PRIORITY_MODE(prio_l), .PERIPH_IRQ(irq_l));

   periph_irq_flags #(.LARGE_VARIANT(1'b0)) dut_small (
      .CLK_SYS(clk_sys), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
      .WR_EN(wr_en), .RD_EN(rd_en), .RDATA(rdata_s), .EV_TWO(ev_two),
      .NVM_WRITE_BUSY(nvm_busy), .ECCP_PWM_MODE(pwm_mode),
      .EV_CAN(ev_can), .CAN_MODE(can_mode), .FLAGS_ONE(flags_one),
      .ENABLES_TWO(en_two), .ENABLES_THREE(en_three),
      .PRIORITY_MODE(), .PERIPH_IRQ(irq_s));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
         miscompares++;
      end
   endtask : chk

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk_sys);
      wr_en <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [2:0] a);
      @(posedge clk_sys);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1;
      rl = rdata_l;
      rs = rdata_s;
      // Return on a rising edge so callers drive inputs there
      @(posedge clk_sys);
   endtask : rd

   task automatic irq_is(input logic e);
      repeat (2) @(posedge clk_sys);
      #1;
      chk({7'h00, irq_l}, {7'h00, e});
      chk({7'h00, irq_s}, {7'h00, e});
      @(posedge clk_sys);
   endtask : irq_is

   task automatic t_reset_values();
      for (int a = 0; a < 8; a++) begin
         rd(3'(a));
         chk(rl, 8'h00);
      end
      #1;
      chk(rdata_l, RST_RDATA);
      chk({6'h00, prio_l, irq_l}, 8'h00);
   endtask : t_reset_values

   task automatic t_group_two();
      logic [7:0] e;
      for (int i = 0; i < 8; i++) begin
         e = (i == TWO_UNUSED_BIT) ? 8'h00 : 8'h01 << i;
         ev.fire(flags_two_s'(8'h01 << i), '0);
         rd(OFS_FLAGS_TWO);
         chk(rl, e);
         chk(rs, e & 8'hBE);
         wr(OFS_FLAGS_TWO, 8'h00);
         rd(OFS_FLAGS_TWO);
         chk(rl, 8'h00);
      end
   endtask : t_group_two

   task automatic t_hold_zero();
      nvm_busy <= 1'b1;
      ev.fire(flags_two_s'(8'h10), '0);
      rd(OFS_FLAGS_TWO);
      chk(rl, 8'h00);
      nvm_busy <= 1'b0;
      pwm_mode <= 1'b1;
      ev.fire(flags_two_s'(8'h01), '0);
      rd(OFS_FLAGS_TWO);
      chk(rl, 8'h00);
      pwm_mode <= 1'b0;
      fork
         ev.fire(flags_two_s'(8'h02), '0);
         wr(OFS_FLAGS_TWO, 8'h00);
      join
      rd(OFS_FLAGS_TWO);
      chk(rl, 8'h02);
      wr(OFS_FLAGS_TWO, 8'h00);
   endtask : t_hold_zero

   task automatic t_can_modes();
      for (int m = 0; m < 4; m++) begin
         can_mode <= 2'(m);
         ev.fire('0, can_events_s'(11'h7FF));
         rd(OFS_CAN_FLAGS);
         chk(rl, exp_all[m]);
         wr(OFS_CAN_FLAGS, 8'h00);
         ev.fire('0, can_events_s'(11'h0EC));
         rd(OFS_CAN_FLAGS);
         chk(rl, exp_leg[m]);
         wr(OFS_CAN_FLAGS, 8'h00);
      end
   endtask : t_can_modes

   task automatic t_request();
      // Small variant: software keeps the parallel port enable clear
      for (int i = 0; i < 7; i++) begin
         flags_one <= 8'h01 << i;
         wr(OFS_ENABLES_ONE, 8'h01 << i);
         irq_is(1'b0);
         wr(OFS_IRQ_CTRL, 8'h02);
         irq_is(1'b1);
         wr(OFS_ENABLES_ONE, ~(8'h81 << i) & 8'h7F);
         irq_is(1'b0);
         wr(OFS_IRQ_CTRL, 8'h00);
      end
      wr(OFS_ENABLES_ONE, 8'hA5);
      rd(OFS_ENABLES_ONE);
      chk(rl, 8'hA5);
      flags_one <= 8'h04;
      wr(OFS_IRQ_CTRL, 8'h03);
      irq_is(1'b1);
      rd(OFS_IRQ_CTRL);
      chk(rl, 8'h03);
      chk({7'h00, prio_l}, 8'h01);
      wr(OFS_IRQ_CTRL, 8'h01);
      irq_is(1'b0);
      flags_one <= 8'h00;
      wr(OFS_IRQ_CTRL, 8'h02);
      en_two <= 8'h80;
      ev.fire(flags_two_s'(8'h80), '0);
      irq_is(1'b1);
      wr(OFS_FLAGS_TWO, 8'h00);
      irq_is(1'b0);
      can_mode <= 2'h0;
      ev.fire('0, can_events_s'(11'h7FF));
      can_mode <= 2'h1;
      rd(OFS_CAN_FLAGS);
      chk(rl, 8'hF2);
      en_three <= 8'h0D;
      irq_is(1'b0);
      en_three <= 8'h80;
      irq_is(1'b1);
   endtask : t_request

   task automatic close_out();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : close_out

   // Whole run is a few hundred cycles; this is many times that
   initial begin
      #(20 * 40000);
      miscompares++;
      close_out();
   end

   initial begin
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      t_reset_values();
      t_group_two();
      t_hold_zero();
      t_can_modes();
      t_request();
      close_out();
   end
endmodule : periph_irq_flags_tb_top
